/* verif/hlrs_chk.sv */
`timescale 1ns/1ps
`include "hlrs_defines.vh"
module hlrs_chk (
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire        fetch_valid_i,
  input wire [2:0]  stack_op_i,
  input wire        move_wr_i,
  input wire        move_rd_i,
  input wire [2:0]  move_sel_i,
  input wire [23:0] move_data_o,
  input wire        next_ip_valid_o,
  input wire        status_valid_o,
  input wire        loop_active_o,
  input wire [5:0]  stack_depth_pointer_o,
  input wire        stack_error_irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [5:0] p = stack_depth_pointer_o;
  reg        past_fv;
  reg  [2:0] past_op;
  reg  [2:0] since_wr;
  wire       quiet = !fetch_valid_i && !past_fv && p[3:0] != 4'h0 && !p[4]
                     && past_op != `HLRS_OP_LOOP && past_op != `HLRS_OP_ABORT;
  // Previous-cycle copies for the idle test
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      past_fv <= 1'b0;
      past_op <= 3'h0;
    end else begin
      past_fv <= fetch_valid_i;
      past_op <= stack_op_i;
    end
  end
  // Pointer copy lags the write by one cycle, so a clear shows up one cycle after the write
  always @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i) since_wr <= 3'h7;
    else if (move_wr_i && move_sel_i == `HLRS_SEL_PTR) since_wr <= 3'h0;
    else if (since_wr != 3'h7) since_wr <= since_wr + 3'h1;
  chk_irq_pulse: assert property (stack_error_irq_o |=> !stack_error_irq_o)
    else $error("stack error request longer than one cycle");
  chk_irq_cause: assert property (stack_error_irq_o |-> ##[0:2] p[4])
    else $error("stack error request without fault flag");
  chk_fault_sticky: assert property ($fell(p[4]) |-> since_wr <= 3'h3)
    else $error("fault flag cleared without pointer write");
  chk_uf_frozen: assert property (p[4] && $past(p[4]) && since_wr == 3'h7 |->
    $stable(p[5]))
    else $error("underflow bit moved while fault set");
  chk_ret_redirect: assert property (stack_op_i == `HLRS_OP_SUBRET && quiet |->
    ##[1:2] next_ip_valid_o)
    else $error("subroutine return gave no redirect");
  chk_rti_status: assert property (stack_op_i == `HLRS_OP_INTRET && quiet |->
    ##[1:2] status_valid_o)
    else $error("interrupt return gave no status");
  chk_status_cause: assert property (status_valid_o |->
    $past(stack_op_i) == `HLRS_OP_INTRET || $past(stack_op_i, 2) == `HLRS_OP_INTRET)
    else $error("status restored without interrupt return");
  chk_ptr_upper: assert property (move_rd_i && move_sel_i == `HLRS_SEL_PTR |=>
    move_data_o[23:6] == 18'h0)
    else $error("pointer upper bits not zero");
  chk_mode_resv: assert property (move_rd_i && move_sel_i == `HLRS_SEL_OMODE |=>
    (move_data_o & ~`HLRS_OMODE_MASK) == 24'h0)
    else $error("reserved mode bits not zero");
  chk_loop_cause: assert property ($rose(loop_active_o) |->
    $past(stack_op_i) == `HLRS_OP_LOOP || $past(stack_op_i, 2) == `HLRS_OP_LOOP
    || $past(stack_op_i) == `HLRS_OP_INTRET || $past(stack_op_i, 2) == `HLRS_OP_INTRET)
    else $error("loop flag rose without loop start");
  cov_irq: cover property (stack_error_irq_o);
  cov_loop: cover property ($rose(loop_active_o));
  cov_rti: cover property (status_valid_o);
endmodule // hlrs_chk
bind hlrs_loop_stack hlrs_chk u_chk (.ref_clk_i, .rst_n_i, .fetch_valid_i, .stack_op_i, .move_wr_i,
  .move_rd_i, .move_sel_i, .move_data_o, .next_ip_valid_o, .status_valid_o, .loop_active_o,
  .stack_depth_pointer_o, .stack_error_irq_o);

/* verif/hlrs_core_model.sv */
`timescale 1ns/1ps
module hlrs_core_model (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        run_i,
  input  wire [15:0] start_i,
  input  wire [15:0] next_ip_i,
  input  wire        next_ip_valid_i,
  input  wire [15:0] status_i,
  input  wire        status_valid_i,
  input  wire        irq_i,
  output reg  [15:0] fetch_addr_o,
  output reg         fetch_valid_o,
  output reg  [15:0] last_ip_o,
  output reg  [15:0] last_st_o,
  output reg  [7:0]  rcnt_o,
  output reg  [7:0]  scnt_o,
  output reg  [7:0]  icnt_o
);
  reg [15:0] pc;
  reg        ph;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {pc, ph, last_ip_o, last_st_o, rcnt_o, scnt_o, icnt_o} <= 0;
    end else begin
      ph <= run_i & ~ph;
      if (!run_i) pc <= start_i;
      else if (next_ip_valid_i) pc <= next_ip_i;
      else if (ph) pc <= pc + 16'h0001;
      if (next_ip_valid_i) {last_ip_o, rcnt_o} <= {next_ip_i, rcnt_o + 8'h01};
      if (status_valid_i) {last_st_o, scnt_o} <= {status_i, scnt_o + 8'h01};
      if (irq_i) icnt_o <= icnt_o + 8'h01;
    end
  end
  // An idle fetch bus shows no stale address
  always @(negedge ref_clk_i) begin
    fetch_valid_o <= ph;
    fetch_addr_o <= ph ? pc : ~pc;
  end
endmodule // hlrs_core_model

/* verif/test_hlrs_loop_stack.sv */
`timescale 1ns/1ps
`include "hlrs_defines.vh"
module test_hlrs_loop_stack;
  reg         ref_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [2:0]  stack_op_i = 3'h0;
  reg  [2:0]  move_sel_i = 3'h0;
  reg  [15:0] ip_i = 16'h0, status_i = 16'h0, loop_end_i = 16'h0;
  reg         move_wr_i = 1'b0, move_rd_i = 1'b0, run = 1'b0;
  reg  [23:0] move_data_i = 24'h0, d;
  wire [23:0] move_data_o;
  wire [15:0] fa, next_ip_o, status_o, loop_count_o, last_ip, last_st;
  wire        fv, nv, sv, loop_active_o, irq, lav;
  wire [5:0]  ptr;
  wire [7:0]  rcnt, scnt, icnt;
  reg  [31:0] e, f;
  reg  [7:0]  n0;
  reg  [31:0] q[$];
  int         error_cnt = 0, num_checks = 0, i, t, lav_cnt = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  // Restore pulses last one cycle, so a falling-edge count sees each once
  always @(negedge ref_clk_i) if (lav === 1'b1) lav_cnt++;
  hlrs_loop_stack dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fetch_addr_i(fa),
    .fetch_valid_i(fv), .stack_op_i(stack_op_i), .ip_i(ip_i), .status_i(status_i),
    .loop_end_i(loop_end_i), .move_wr_i(move_wr_i), .move_rd_i(move_rd_i),
    .move_sel_i(move_sel_i), .move_data_i(move_data_i), .move_data_o(move_data_o),
    .next_ip_o(next_ip_o), .next_ip_valid_o(nv), .status_o(status_o), .status_valid_o(sv),
    .loop_active_o(loop_active_o), .loop_active_valid_o(lav), .loop_count_o(loop_count_o),
    .stack_depth_pointer_o(ptr), .stack_error_irq_o(irq));
  hlrs_core_model core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .run_i(run),
    .start_i(16'h0030), .next_ip_i(next_ip_o), .next_ip_valid_i(nv), .status_i(status_o),
    .status_valid_i(sv), .irq_i(irq), .fetch_addr_o(fa), .fetch_valid_o(fv),
    .last_ip_o(last_ip), .last_st_o(last_st), .rcnt_o(rcnt), .scnt_o(scnt), .icnt_o(icnt));
  task complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task op(input [2:0] c, input [15:0] le);
    e = $urandom;
    if (c == `HLRS_OP_LOOP) e = 32'h0030_0000;
    @(negedge ref_clk_i) {stack_op_i, ip_i, status_i, loop_end_i} = {c, e, le};
    @(negedge ref_clk_i) stack_op_i = 3'h0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  task mw(input [2:0] s, input [23:0] v);
    @(negedge ref_clk_i) {move_wr_i, move_sel_i, move_data_i} = {1'b1, s, v};
    @(negedge ref_clk_i) move_wr_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  task mr(input [2:0] s);
    @(negedge ref_clk_i) {move_rd_i, move_sel_i} = {1'b1, s};
    @(negedge ref_clk_i) move_rd_i = 1'b0;
    @(negedge ref_clk_i) d = move_data_o;
  endtask
  task wt(input [7:0] n);
    t = 0;
    while (rcnt !== n && t < 2000) begin
      @(negedge ref_clk_i);
      t++;
    end
    if (t >= 2000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: no loop redirect", $time);
      complete_run;
    end
  endtask
  initial begin
    void'($urandom(89));
    repeat (6) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk(ptr, 0);
    e = $urandom;
    mw(`HLRS_SEL_LCNT, {8'h00, e[15:0]});
    mr(`HLRS_SEL_LCNT);
    chk(d[15:0], e[15:0]);
    chk(loop_count_o, e[15:0]);
    mr(`HLRS_SEL_PTR);
    chk(d, 0);
    mr(`HLRS_SEL_OMODE);
    chk(d & ~`HLRS_OMODE_MASK, 0);
    for (i = 1; i <= 15; i++) begin
      op(`HLRS_OP_CALL, 0);
      q.push_back(e);
      chk(ptr, i[5:0]);
    end
    n0 = icnt;
    op(`HLRS_OP_CALL, 0);
    chk(ptr, 6'h10);
    chk(icnt, n0 + 8'h01);
    mw(`HLRS_SEL_PTR, 24'h00000F);
    chk(ptr, 6'h0F);
    n0 = scnt;
    f = q.pop_back();
    op(`HLRS_OP_SUBRET, 0);
    chk(last_ip, f[31:16]);
    chk(scnt, n0);
    f = q.pop_back();
    op(`HLRS_OP_INTRET, 0);
    chk({last_ip, last_st}, f);
    while (q.size() > 0) begin
      f = q.pop_back();
      op(`HLRS_OP_SUBRET, 0);
      chk(last_ip, f[31:16]);
    end
    n0 = icnt;
    op(`HLRS_OP_SUBRET, 0);
    chk(ptr, 6'h3F);
    op(`HLRS_OP_SUBRET, 0);
    chk(ptr, 6'h3E);
    chk(icnt, n0 + 8'h01);
    mw(`HLRS_SEL_PTR, 24'h000000);
    mw(`HLRS_SEL_LOW, 24'h001234);
    mr(`HLRS_SEL_LOW);
    chk({ptr, icnt}, {6'h00, n0 + 8'h01});
    mw(`HLRS_SEL_LCNT, 24'h000003);
    op(`HLRS_OP_LOOP, 16'h0040);
    chk({ptr, loop_active_o}, {6'h02, 1'b1});
    n0 = rcnt;
    run = 1'b1;
    wt(n0 + 8'h01);
    chk({last_ip, loop_count_o}, {16'h0030, 16'h0002});
    wt(n0 + 8'h03);
    run = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk({last_ip, loop_count_o}, {16'h0041, 16'h0003});
    chk({ptr, loop_active_o}, 0);
    mw(`HLRS_SEL_LCNT, 24'h000005);
    op(`HLRS_OP_LOOP, 16'h0040);
    mw(`HLRS_SEL_LCNT, 24'h000007);
    op(`HLRS_OP_ABORT, 0);
    chk({ptr, loop_count_o}, {6'h00, 16'h0005});
    op(`HLRS_OP_REPEAT, 0);
    op(`HLRS_OP_REPSTEP, 0);
    chk({ptr, loop_count_o}, {6'h00, 16'h0004});
    chk(lav_cnt, 2);
    mw(`HLRS_SEL_PTR, 24'h000021);
    op(`HLRS_OP_CALL, 0);
    chk(ptr, 6'h02);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    complete_run;
  end
endmodule // test_hlrs_loop_stack

/* verilog/hlrs_defines.vh */
`ifndef HLRS_DEFINES_VH
`define HLRS_DEFINES_VH
// Pointer register layout
`define HLRS_PTR_W        6
`define HLRS_PTR_FIELD_HI 3
`define HLRS_FAULT_BIT    4
`define HLRS_UNDER_BIT    5
`define HLRS_PTR_RESET    6'h00
`define HLRS_PTR_FULL     4'hF
// Stack geometry
`define HLRS_DEPTH        15
`define HLRS_BANK_W       16
// Control register select for moves
`define HLRS_SEL_W        3
`define HLRS_SEL_PTR      3'h0
`define HLRS_SEL_LCNT     3'h1
`define HLRS_SEL_LEND     3'h2
`define HLRS_SEL_HIGH     3'h3
`define HLRS_SEL_LOW      3'h4
`define HLRS_SEL_OMODE    3'h5
// Operating-mode implemented bits: 0..2, 6, 7
`define HLRS_OMODE_MASK   24'h0000C7
// Stack operation codes
`define HLRS_OP_W         3
`define HLRS_OP_NONE      3'h0
`define HLRS_OP_CALL      3'h1
`define HLRS_OP_SUBRET    3'h2
`define HLRS_OP_INTRET    3'h3
`define HLRS_OP_LOOP      3'h4
`define HLRS_OP_ABORT     3'h5
`define HLRS_OP_REPEAT    3'h6
`define HLRS_OP_REPSTEP   3'h7
`endif

/* verilog/hlrs_loop_stack.v */
`timescale 1ns/1ps
`include "hlrs_defines.vh"
// How it works
// R1: At loop end with counter not one, decrement counter, fetch from stack top.
// R2: Counter one at loop end: step on, restore loop flag, pop, restore end and counter.
// R3: Loop iteration counter is 16 bits, readable and writable by software.
// R4: Loop start pushes end:counter, then instruction pointer:status word.
// R5: End address and counter restored at loop termination and at loop abort.
// R6: Single-instruction repeat uses the loop iteration counter as its count.
// R7: Stack is 15 entries of two 16-bit banks, high and low.
// R8: Call or long interrupt pushes instruction pointer and status word together.
// R9: Subroutine return pulls instruction pointer only, status word untouched.
// R10: Interrupt return pulls both instruction pointer and status word.
// R11: Overflow raises stack error; pushed pointer goes to absent location zero.
// R12: Six-bit depth pointer; low four bits select the stack location.
// R13: Push increments then writes; pull reads then decrements.
// R14: Reset clears the pointer field, stack empty.
// R15: Fault flag is bit 4; its rising edge raises a level-3 exception. A pointer move that writes 1 to bit 4 sets the flag without raising it.
// R16: Push at 001111 faults giving 010000, or 010001 after double push.
// R17: Pull at zero faults giving 111111, or 111110 after double pull.
// R18: Fault flag stays set until software writes zero to bit 4.
// R19: Underflow bit 5 set on underflow, frozen while fault set until a move.
// R20: Forced underflow with fault clear is corrected by the next stack operation.
// R21: Plain low-bank accesses with pointer zero raise no stack error.
// R22: Unimplemented pointer bits and reserved mode bits read as zero.
module hlrs_loop_stack (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire [15:0] fetch_addr_i,
  input  wire        fetch_valid_i,
  input  wire [2:0]  stack_op_i,
  input  wire [15:0] ip_i,
  input  wire [15:0] status_i,
  input  wire [15:0] loop_end_i,
  input  wire        move_wr_i,
  input  wire        move_rd_i,
  input  wire [2:0]  move_sel_i,
  input  wire [23:0] move_data_i,
  output reg  [23:0] move_data_o,
  output reg  [15:0] next_ip_o,
  output reg         next_ip_valid_o,
  output reg  [15:0] status_o,
  output reg         status_valid_o,
  output reg         loop_active_o,
  output reg         loop_active_valid_o,
  output reg  [15:0] loop_count_o,
  output reg  [5:0]  stack_depth_pointer_o,
  output reg         stack_error_irq_o
);
  reg  [5:0]  stack_depth_pointer;
  reg  [15:0] loop_iteration_counter;
  reg  [15:0] loop_end_address;
  reg  [23:0] op_mode;
  reg  [5:0]  next_ptr;
  reg  [3:0]  wr_addr;
  reg  [3:0]  rd_addr;
  reg         wr_high;
  reg         wr_low;
  reg  [15:0] wr_high_data;
  reg  [15:0] wr_low_data;
  reg         pending_second;
  reg         loop_pop;
  wire [15:0] top_high;
  wire [15:0] top_low;
  wire        loop_end_hit;
  wire        ptr_write;
  wire        low_move_wr;
  wire        move_en;
  wire        high_move_wr;
  wire        lcnt_wr;
  wire        lend_wr;
  wire        omode_wr;

  // Four-bit wrap is the designed 6-bit counter behaviour
  function [5:0] hlrs_step;
    input [5:0] ptr;
    input       up;
    begin
      hlrs_step = up ? ptr + 6'h01 : ptr - 6'h01;
    end
  endfunction

  // Flags after a push or pull step: overflow/underflow latch unless fault set
  function [5:0] hlrs_flags;
    input [5:0] old_ptr;
    input [5:0] new_ptr;
    input       up;
    reg         err;
    reg         under;
    begin
      err   = old_ptr[`HLRS_FAULT_BIT];
      under = old_ptr[`HLRS_UNDER_BIT];
      if (!err) begin
        // Forced underflow with fault clear is recomputed here
        under = 1'b0; // see R20
        if (up && old_ptr[3:0] == `HLRS_PTR_FULL) begin
          err = 1'b1; // see R16
        end else if (!up && old_ptr[3:0] == 4'h0) begin
          err   = 1'b1; // see R17
          under = 1'b1; // see R19
        end
      end
      hlrs_flags = {under, err, new_ptr[3:0]}; // see R19
    end
  endfunction

  // Pointer and flags after a single push or pull
  function [5:0] hlrs_push_ptr;
    input [5:0] ptr;
    begin
      hlrs_push_ptr = hlrs_flags(ptr, hlrs_step(ptr, 1'b1), 1'b1); // see R13
    end
  endfunction

  function [5:0] hlrs_pull_ptr;
    input [5:0] ptr;
    begin
      hlrs_pull_ptr = hlrs_flags(ptr, hlrs_step(ptr, 1'b0), 1'b0); // see R13
    end
  endfunction

  assign loop_end_hit = fetch_valid_i && loop_active_o && fetch_addr_i == loop_end_address;
  // Move writes only count in a cycle with no stack operation; reads are not gated
  assign move_en      = move_wr_i && stack_op_i == `HLRS_OP_NONE;
  assign ptr_write    = move_en && move_sel_i == `HLRS_SEL_PTR;
  assign low_move_wr  = move_en && move_sel_i == `HLRS_SEL_LOW;
  assign high_move_wr = move_en && move_sel_i == `HLRS_SEL_HIGH;
  assign lcnt_wr      = move_en && move_sel_i == `HLRS_SEL_LCNT;
  assign lend_wr      = move_en && move_sel_i == `HLRS_SEL_LEND;
  assign omode_wr     = move_en && move_sel_i == `HLRS_SEL_OMODE;

  hlrs_stack_mem u_mem ( // see R7
    .ref_clk_i (ref_clk_i),
    .addr_i    (wr_addr),
    .wr_high_i (wr_high),
    .wr_low_i  (wr_low),
    .high_i    (wr_high_data),
    .low_i     (wr_low_data),
    .raddr_i   (rd_addr),
    .high_o    (top_high),
    .low_o     (top_low)
  );

  // Stack sequencing: one pointer step per cycle, double ops take two
  always @* begin
    next_ptr     = stack_depth_pointer;
    wr_addr      = stack_depth_pointer[3:0];
    rd_addr      = stack_depth_pointer[3:0]; // see R12
    wr_high      = 1'b0;
    wr_low       = 1'b0;
    wr_high_data = ip_i;
    wr_low_data  = status_i;
    if (pending_second) begin
      if (loop_pop) begin
        // Second pull of loop exit: end address and counter
        next_ptr = hlrs_pull_ptr(stack_depth_pointer); // see R13
      end else begin
        next_ptr     = hlrs_push_ptr(stack_depth_pointer);
        wr_addr      = next_ptr[3:0]; // see R13
        wr_high      = 1'b1; // see R4
        wr_low       = 1'b1;
      end
    end else if (loop_end_hit && loop_iteration_counter == 16'h0001) begin
      next_ptr = hlrs_pull_ptr(stack_depth_pointer); // see R2
    end else begin
      case (stack_op_i)
        `HLRS_OP_CALL, `HLRS_OP_LOOP: begin
          next_ptr = hlrs_push_ptr(stack_depth_pointer);
          wr_addr  = next_ptr[3:0]; // see R11 R13
          wr_high  = 1'b1; // see R8
          wr_low   = 1'b1;
          if (stack_op_i == `HLRS_OP_LOOP) begin
            wr_high_data = loop_end_i; // see R4
            wr_low_data  = loop_iteration_counter;
          end
        end
        `HLRS_OP_SUBRET, `HLRS_OP_INTRET, `HLRS_OP_ABORT: begin
          next_ptr = hlrs_pull_ptr(stack_depth_pointer); // see R13
        end
        default: begin
          // Low-bank moves touch the top entry without a pointer step
          if (low_move_wr) begin
            wr_low      = 1'b1; // see R21
            wr_low_data = move_data_i[15:0];
          end else if (high_move_wr) begin
            next_ptr     = hlrs_push_ptr(stack_depth_pointer);
            wr_addr      = next_ptr[3:0];
            wr_high      = 1'b1;
            wr_high_data = move_data_i[15:0];
          end
        end
      endcase
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stack_depth_pointer    <= `HLRS_PTR_RESET; // see R14
      loop_iteration_counter <= 16'h0000;
      loop_end_address       <= 16'h0000;
      op_mode                <= 24'h000000;
      pending_second         <= 1'b0;
      loop_pop               <= 1'b0;
      next_ip_o              <= 16'h0000;
      next_ip_valid_o        <= 1'b0;
      status_o               <= 16'h0000;
      status_valid_o         <= 1'b0;
      loop_active_o          <= 1'b0;
      loop_active_valid_o    <= 1'b0;
      stack_error_irq_o      <= 1'b0;
      move_data_o            <= 24'h000000;
    end else begin
      next_ip_valid_o     <= 1'b0;
      status_valid_o      <= 1'b0;
      loop_active_valid_o <= 1'b0;
      pending_second      <= 1'b0;
      stack_depth_pointer <= next_ptr;
      // Rising edge of the fault flag from a stack step only; a pointer move, set or clear, has no effect here
      stack_error_irq_o   <= next_ptr[`HLRS_FAULT_BIT] &&
                             !stack_depth_pointer[`HLRS_FAULT_BIT]; // see R15
      if (pending_second) begin
        if (loop_pop) begin
          loop_end_address       <= top_high; // see R5
          loop_iteration_counter <= top_low;
        end
      end else if (loop_end_hit) begin
        next_ip_valid_o <= 1'b1;
        if (loop_iteration_counter != 16'h0001) begin
          loop_iteration_counter <= loop_iteration_counter - 16'h0001; // see R1
          next_ip_o              <= top_high; // see R1
        end else begin
          next_ip_o           <= fetch_addr_i + 16'h0001; // see R2
          loop_active_o       <= top_low[15];
          loop_active_valid_o <= 1'b1;
          pending_second      <= 1'b1;
          loop_pop            <= 1'b1;
        end
      end else begin
        case (stack_op_i)
          `HLRS_OP_LOOP: begin
            loop_end_address <= loop_end_i;
            loop_active_o    <= 1'b1;
            pending_second   <= 1'b1;
            loop_pop         <= 1'b0;
          end
          `HLRS_OP_SUBRET: begin
            next_ip_o       <= top_high; // see R9
            next_ip_valid_o <= 1'b1;
          end
          `HLRS_OP_INTRET: begin
            next_ip_o       <= top_high; // see R10
            next_ip_valid_o <= 1'b1;
            status_o        <= top_low; // see R10
            status_valid_o  <= 1'b1;
            loop_active_o   <= top_low[15];
          end
          `HLRS_OP_ABORT: begin
            loop_active_o       <= top_low[15];
            loop_active_valid_o <= 1'b1;
            pending_second      <= 1'b1;
            loop_pop            <= 1'b1;
          end
          `HLRS_OP_REPSTEP: begin
            loop_iteration_counter <= loop_iteration_counter - 16'h0001; // see R6
          end
          default: begin
            if (ptr_write) begin
              // Direct move: fault clears only by an explicit zero in bit 4
              stack_depth_pointer <= {move_data_i[`HLRS_UNDER_BIT],
                                      move_data_i[`HLRS_FAULT_BIT] &
                                      stack_depth_pointer[`HLRS_FAULT_BIT] |
                                      move_data_i[`HLRS_FAULT_BIT],
                                      move_data_i[3:0]}; // see R18
            end
            if (lcnt_wr)
              loop_iteration_counter <= move_data_i[15:0]; // see R3
            if (lend_wr)
              loop_end_address <= move_data_i[15:0];
            if (omode_wr)
              op_mode <= move_data_i & `HLRS_OMODE_MASK; // see R22
          end
        endcase
      end
      // Reads: unimplemented upper bits return zero
      if (move_rd_i) begin
        case (move_sel_i)
          `HLRS_SEL_PTR:   move_data_o <= {18'h00000, stack_depth_pointer}; // see R22
          `HLRS_SEL_LCNT:  move_data_o <= {8'h00, loop_iteration_counter}; // see R3
          `HLRS_SEL_LEND:  move_data_o <= {8'h00, loop_end_address};
          `HLRS_SEL_HIGH:  move_data_o <= {8'h00, top_high};
          `HLRS_SEL_LOW:   move_data_o <= {8'h00, top_low}; // see R21
          `HLRS_SEL_OMODE: move_data_o <= op_mode & `HLRS_OMODE_MASK; // see R22
          default:         move_data_o <= 24'h000000;
        endcase
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_count_o          <= 16'h0000;
      stack_depth_pointer_o <= `HLRS_PTR_RESET;
    end else begin
      loop_count_o          <= loop_iteration_counter;
      stack_depth_pointer_o <= stack_depth_pointer;
    end
  end
endmodule // hlrs_loop_stack

/* verilog/hlrs_stack_mem.v */
`timescale 1ns/1ps
`include "hlrs_defines.vh"
module hlrs_stack_mem (
  input  wire        ref_clk_i,
  input  wire [3:0]  addr_i,
  input  wire        wr_high_i,
  input  wire        wr_low_i,
  input  wire [15:0] high_i,
  input  wire [15:0] low_i,
  input  wire [3:0]  raddr_i,
  output wire [15:0] high_o,
  output wire [15:0] low_o
);
  // Location zero is not implemented; writes there are dropped
  reg [15:0] high_bank [1:`HLRS_DEPTH];
  reg [15:0] low_bank  [1:`HLRS_DEPTH];

  always @(posedge ref_clk_i) begin
    if (wr_high_i && addr_i != 4'h0)
      high_bank[addr_i] <= high_i; // see R7
    if (wr_low_i && addr_i != 4'h0)
      low_bank[addr_i] <= low_i; // see R7
  end

  assign high_o = (raddr_i == 4'h0) ? 16'h0000 : high_bank[raddr_i];
  assign low_o  = (raddr_i == 4'h0) ? 16'h0000 : low_bank[raddr_i];
endmodule // hlrs_stack_mem
